// file: hdl/group_priority_pick.sv
// Per-group pick of requested level and winning result bit
`timescale 1ns/100ps
`include "irq_encoder_consts.svh"
module group_priority_pick (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] result,
  input wire logic [63:0] prio,
  input wire logic jump_table_select,
  output irq_encoder_pkg::level_type level,
  output irq_encoder_pkg::bit_index_type bit_index
);

  always_comb
  begin
    irq_encoder_pkg::level_type cand;
    cand = 3'h0;
    level = 3'h0;
    bit_index = 5'h00;
    if (!jump_table_select)
    begin
      // Whole group rides on bit 0's setting
      if (|result)
        level = {1'b0, prio[1:0]} + 3'h1;
    end
    else
    begin
      for (int i = 0; i < 32; i++)
      begin
        cand = result[i] ? ({1'b0, prio[2*i +: 2]} + 3'h1) : 3'h0;
        // Strict compare keeps the lowest bit on a tie
        if (cand > level)
        begin
          level = cand;
          bit_index = i[4:0];
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  agg_level_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!jump_table_select && |result) |-> (level == {1'b0, prio[1:0]} + 3'h1 && bit_index == 5'h00))
    else $error("aggregated group level not taken from bit 0");

  disagg_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (jump_table_select && level != 3'h0) |-> (result[bit_index]
      && level == {1'b0, prio[2*bit_index +: 2]} + 3'h1))
    else $error("disaggregated winner bit not active or level wrong");

endmodule : group_priority_pick

// file: hdl/grouped_irq_priority_encoder.sv
// Grouped interrupt priority encoder with Avalon-MM register slave
// How it works
// - Every result bit of every group has its own programmable priority level.
// - Highest requested level under the current mode is always presented.
// - Each group picks aggregated or jump-table mode by its own select bit.
// - Group 23 bits 8, 9, 10 carry second tick, sub-second tick, power present.
// - Group 23 bits 11 to 13 carry override and two control inputs; 14-15 reserved.
// - Host virtual wires fill group 25 bits 0-27 and group 26 bits 0-11.
// - Aggregated groups use bit 0's priority; other priority fields do nothing.
// - Group active when any result bit set; lowest group wins a tie.
// - Jump-table mode: per-bit priority, lowest bit wins a tie, vector base plus 8*bit.
// - Control bit 0 selects mode, bits 17 to 1 hold vector offset.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
`include "irq_encoder_consts.svh"
module grouped_irq_priority_encoder (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [`NUM_GROUPS*32-1:0] group_result_in,
  input wire logic week_one_second_tick,
  input wire logic week_sub_second_tick,
  input wire logic system_power_present_event,
  input wire logic battery_override_input,
  input wire logic battery_control_input_a,
  input wire logic battery_control_input_b,
  input wire logic [`HVW_W-1:0] host_virtual_wire_source,
  output irq_encoder_pkg::level_type requested_priority_level,
  output irq_encoder_pkg::vector_type irq_vector,
  output irq_encoder_pkg::group_number_type interrupt_group
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [17:0] ctrl_r [`NUM_GROUPS];
  logic [63:0] prio_r [`NUM_GROUPS];
  logic [31:0] merged [`NUM_GROUPS];
  irq_encoder_pkg::level_type grp_level [`NUM_GROUPS];
  irq_encoder_pkg::bit_index_type grp_bit [`NUM_GROUPS];
  irq_encoder_pkg::level_type best_level;
  irq_encoder_pkg::vector_type best_vector;
  irq_encoder_pkg::group_number_type best_group;
  logic waitrequest_r;
  logic [31:0] readdata_r;
  irq_encoder_pkg::level_type level_r;
  irq_encoder_pkg::vector_type vector_r;
  irq_encoder_pkg::group_number_type group_r;

  function automatic logic [31:0] source_mask(input int g);
    if (g == `G23_IDX)
      return `MASK_G23;
    else if (g == `G25_IDX)
      return `MASK_G25;
    else if (g == `G26_IDX)
      return `MASK_G26;
    else
      return `MASK_DEFAULT;
  endfunction : source_mask

  // ----------------------------------------
  // Source mapping
  // ----------------------------------------
  wire [5:0] week_vci_events = {battery_control_input_b, battery_control_input_a,
    battery_override_input, system_power_present_event, week_sub_second_tick,
    week_one_second_tick};

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req = avs_read | avs_write;
  wire accept = req & ~waitrequest_r;
  wire [5:0] word_grp = avs_address[9:4];
  wire [3:0] word_off = avs_address[3:0];
  wire grp_hit = (word_grp < 6'(`NUM_GROUPS));
  wire [4:0] gi = word_grp[4:0];
  wire status_hit = (avs_address == `STATUS_ADDR);
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire wr_ctrl = avs_write & accept & grp_hit & (word_off == `OFF_CTRL);
  wire wr_plo = avs_write & accept & grp_hit & (word_off == `OFF_PRIO_LO);
  wire wr_phi = avs_write & accept & grp_hit & (word_off == `OFF_PRIO_HI);
  wire [31:0] rd_data =
    status_hit ? {6'h00, vector_r, group_r, level_r} :
    !grp_hit ? 32'h00000000 :
    (word_off == `OFF_CTRL) ? {14'h0000, ctrl_r[gi]} :
    (word_off == `OFF_PRIO_LO) ? prio_r[gi][31:0] :
    (word_off == `OFF_PRIO_HI) ? prio_r[gi][63:32] :
    (word_off == `OFF_RESULT) ? merged[gi] : 32'h00000000;

  // One wait state: request seen, then released on the next edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      waitrequest_r <= 1'b1;
    else
      waitrequest_r <= ~(req & waitrequest_r);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      readdata_r <= 32'h00000000;
    else if (avs_read & waitrequest_r)
      readdata_r <= rd_data;
  end

  // ----------------------------------------
  // Per-group registers and encoders
  // ----------------------------------------
  for (genvar g = 0; g < `NUM_GROUPS; g++)
  begin : grp
    wire [31:0] raw;
    if (g == `G23_IDX)
    begin : g23
      assign raw = group_result_in[g*32 +: 32] | (32'(week_vci_events) << `WEEK_EVT_LSB);
    end
    else if (g == `G25_IDX)
    begin : g25
      assign raw = {4'h0, host_virtual_wire_source[`G25_WIRES-1:0]};
    end
    else if (g == `G26_IDX)
    begin : g26
      assign raw = {20'h00000, host_virtual_wire_source[`HVW_W-1:`G25_WIRES]};
    end
    else
    begin : gen
      assign raw = group_result_in[g*32 +: 32];
    end
    // Masking keeps reserved inputs from ever raising a request
    assign merged[g] = raw & source_mask(g);

    always_ff @(posedge clk)
    begin
      if (sys_rst)
        ctrl_r[g] <= `CTRL_RESET;
      else if (wr_ctrl && gi == 5'(g))
        ctrl_r[g] <= (ctrl_r[g] & ~be_mask[17:0]) | (avs_writedata[17:0] & be_mask[17:0]);
    end

    always_ff @(posedge clk)
    begin
      if (sys_rst)
        prio_r[g] <= `PRIO_RESET;
      else if (wr_plo && gi == 5'(g))
        prio_r[g][31:0] <= (prio_r[g][31:0] & ~be_mask) | (avs_writedata & be_mask);
      else if (wr_phi && gi == 5'(g))
        prio_r[g][63:32] <= (prio_r[g][63:32] & ~be_mask) | (avs_writedata & be_mask);
    end

    group_priority_pick pick (
      .clk(clk),
      .sys_rst(sys_rst),
      .result(merged[g]),
      .prio(prio_r[g]),
      .jump_table_select(ctrl_r[g][`JTS_BIT]),
      .level(grp_level[g]),
      .bit_index(grp_bit[g])
    );
  end

  // ----------------------------------------
  // Cross-group decision
  // ----------------------------------------
  always_comb
  begin
    best_level = 3'h0;
    best_group = `FIRST_GROUP;
    best_vector = 18'h00000;
    for (int g = 0; g < `NUM_GROUPS; g++)
    begin
      // Strict compare: the lowest numbered group keeps a tie
      if (grp_level[g] > best_level)
      begin
        best_level = grp_level[g];
        best_group = `FIRST_GROUP + 5'(g);
        best_vector = {ctrl_r[g][`VEC_MSB:`VEC_LSB], 1'b0}
          + (18'(grp_bit[g]) << `VECTOR_SHIFT);
      end
    end
  end

  // Registered so the core sees a glitch-free level and vector
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      level_r <= 3'h0;
      vector_r <= 18'h00000;
      group_r <= `FIRST_GROUP;
    end
    else
    begin
      level_r <= best_level;
      vector_r <= best_vector;
      group_r <= best_group;
    end
  end

  assign avs_waitrequest = waitrequest_r;
  assign avs_readdata = readdata_r;
  assign requested_priority_level = level_r;
  assign irq_vector = vector_r;
  assign interrupt_group = group_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence plo_write_s;
    wr_plo && gi == 5'h00 && avs_byteenable == 4'hF;
  endsequence

  prio_store_a: assert property (plo_write_s |=> prio_r[0][31:0] == $past(avs_writedata))
    else $error("priority write to group 8 not stored");

  for (genvar g = 0; g < `NUM_GROUPS; g++)
  begin : chk
    level_max_a: assert property (1'b1 |=> level_r >= $past(grp_level[g]))
      else $error("presented level below an active group level");
  end

  idle_zero_a: assert property ((best_level == 3'h0) |=> level_r == 3'h0)
    else $error("level presented with nothing pending");

  mode_store_a: assert property ((wr_ctrl && avs_byteenable[0]) |=>
    ctrl_r[$past(gi)][`JTS_BIT] == $past(avs_writedata[0]))
    else $error("jump table select not stored");

  // Plain group inputs on bits 8 to 13 are ORed in, so they are legal here
  week_map_a: assert property (merged[`G23_IDX][15:8] == ({2'b00, week_vci_events}
    | {2'b00, group_result_in[`G23_IDX*32+8 +: 6]}))
    else $error("group 23 event bits misplaced");

  wire_map_a: assert property (
    merged[`G25_IDX] == {4'h0, host_virtual_wire_source[27:0]}
    && merged[`G26_IDX] == {20'h00000, host_virtual_wire_source[39:28]})
    else $error("virtual wire bits misplaced");

  tie_low_a: assert property ((grp_level[0] != 3'h0 && grp_level[0] == best_level)
    |=> group_r == `FIRST_GROUP)
    else $error("lowest group lost a tie");

  vec_calc_a: assert property ((best_level != 3'h0 && best_group == `FIRST_GROUP)
    |=> vector_r == {$past(ctrl_r[0][17:1]), 1'b0} + (18'($past(grp_bit[0])) << 3))
    else $error("vector not base plus eight times bit");

  reserved_a: assert property ((merged[`G23_IDX][15:14] == 2'b00) && !merged[0][31])
    else $error("reserved source position set");

endmodule : grouped_irq_priority_encoder

// file: hdl/irq_encoder_consts.svh
// Offsets, field positions, masks and reset values of the grouped interrupt encoder
`ifndef IRQ_ENCODER_CONSTS_SVH
`define IRQ_ENCODER_CONSTS_SVH

// ----------------------------------------
// Group numbering
// ----------------------------------------
`define NUM_GROUPS 19
`define FIRST_GROUP 5'h08
`define G23_IDX 15
`define G25_IDX 17
`define G26_IDX 18

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_W 10
`define OFF_CTRL 4'h0
`define OFF_PRIO_LO 4'h4
`define OFF_PRIO_HI 4'h8
`define OFF_RESULT 4'hC
`define STATUS_ADDR 10'h200

// ----------------------------------------
// Aggregator control fields
// ----------------------------------------
`define JTS_BIT 0
`define VEC_MSB 17
`define VEC_LSB 1
`define CTRL_RESET 18'h00000
`define PRIO_RESET 64'h0000000000000000

// ----------------------------------------
// Vector spacing of 8 bytes, as a shift
// ----------------------------------------
`define VECTOR_SHIFT 3

// ----------------------------------------
// Populated source positions per group
// ----------------------------------------
`define MASK_DEFAULT 32'h7FFFFFFF
`define MASK_G23 32'h00003FFF
`define MASK_G25 32'h0FFFFFFF
`define MASK_G26 32'h00000FFF
`define WEEK_EVT_LSB 8
`define G25_WIRES 28
`define HVW_W 40

`endif

// file: hdl/irq_encoder_pkg.sv
// Types shared by the grouped interrupt encoder files
package irq_encoder_pkg;
  typedef logic [2:0] level_type;
  typedef logic [4:0] bit_index_type;
  typedef logic [17:0] vector_type;
  typedef logic [4:0] group_number_type;
endpackage : irq_encoder_pkg

// file: verif/proc_core_model.sv
// Processor core model on the far side of the requested-level outputs
`timescale 1ns/100ps
module proc_core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] requested_priority_level,
  input wire logic [17:0] irq_vector,
  input wire logic handler_done,
  output irq_encoder_pkg::level_type serviced_priority_level,
  output irq_encoder_pkg::vector_type entered_vector
);
  // ----------------------------------------
  // Preempt or let the running handler finish
  // ----------------------------------------
  // Equal level never preempts, so a tie keeps the running handler
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      serviced_priority_level <= 3'h0;
      entered_vector <= 18'h00000;
    end
    else if (requested_priority_level > serviced_priority_level)
    begin
      serviced_priority_level <= requested_priority_level;
      entered_vector <= irq_vector;
    end
    else if (handler_done)
      serviced_priority_level <= 3'h0;
  end
endmodule : proc_core_model

// file: verif/tb_top.sv
// Self-checking bench for the grouped interrupt priority encoder
`timescale 1ns/100ps
`include "irq_encoder_consts.svh"
module tb_top;
  logic clk;
  logic sys_rst;
  logic [9:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wd;
  logic [31:0] q;
  logic [31:0] rdat;
  logic wreq;
  logic [607:0] res;
  logic [5:0] ev;
  logic [39:0] hvw;
  logic done;
  irq_encoder_pkg::level_type lvl;
  irq_encoder_pkg::level_type srv;
  irq_encoder_pkg::vector_type vec;
  irq_encoder_pkg::vector_type ent;
  irq_encoder_pkg::group_number_type grp;
  int fail_count;
  int comparisons;

  grouped_irq_priority_encoder DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .group_result_in(res),
    .week_one_second_tick(ev[0]), .week_sub_second_tick(ev[1]),
    .system_power_present_event(ev[2]), .battery_override_input(ev[3]),
    .battery_control_input_a(ev[4]), .battery_control_input_b(ev[5]),
    .host_virtual_wire_source(hvw), .requested_priority_level(lvl),
    .irq_vector(vec), .interrupt_group(grp));
  proc_core_model core (.clk(clk), .sys_rst(sys_rst), .requested_priority_level(lvl),
    .irq_vector(vec), .handler_done(done), .serviced_priority_level(srv),
    .entered_vector(ent));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic summarize;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", what, e, g);
    end
  endtask : chk

  // Outputs lag the inputs by one edge, so two edges settle them
  task automatic chk_enc(input logic [2:0] l, input logic [17:0] v, input logic [4:0] g);
    repeat (2) @(posedge clk);
    comparisons++;
    if ({lvl, vec, grp} !== {l, v, g})
    begin
      fail_count++;
      $display("[FAIL] encoder exp %h %h %h got %h %h %h", l, v, g, lvl, vec, grp);
    end
  endtask : chk_enc

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      summarize();
    end
  endtask : bus

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk_enc(3'h0, 18'h00000, 5'h08);
    bus(1'b0, 10'h000, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(1'b0, 10'h004, 32'h0);
    chk("prio", 32'h0, q);
    bus(1'b0, 10'h130, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask : t_reset

  task automatic t_aggr;
    bus(1'b1, 10'h000, 32'h00000500);
    bus(1'b1, 10'h004, 32'h00000001);
    bus(1'b1, 10'h008, 32'h00000300);
    res[20] <= 1'b1;
    chk_enc(3'h2, 18'h00500, 5'h08);
    bus(1'b1, 10'h010, 32'h00000600);
    bus(1'b1, 10'h014, 32'h00000001);
    res[32] <= 1'b1;
    chk_enc(3'h2, 18'h00500, 5'h08);
    res[20] <= 1'b0;
    chk_enc(3'h2, 18'h00600, 5'h09);
    bus(1'b0, 10'h200, 32'h0);
    chk("status", 32'h0006004A, q);
    // Equal level must not preempt the running handler
    chk("core kept", 32'h00000500, {14'h0, ent});
    bus(1'b1, 10'h01C, 32'hFFFFFFFF);
    bus(1'b0, 10'h01C, 32'h0);
    chk("result ro", 32'h00000001, q);
  endtask : t_aggr

  task automatic t_jump;
    res[32] <= 1'b0;
    bus(1'b1, 10'h000, 32'h00000501);
    bus(1'b1, 10'h004, 32'h00000000);
    bus(1'b1, 10'h008, 32'h00000000);
    res[29] <= 1'b1;
    res[2] <= 1'b1;
    chk_enc(3'h1, 18'h00510, 5'h08);
    bus(1'b1, 10'h008, 32'h08000000);
    res[32] <= 1'b1;
    chk_enc(3'h3, 18'h005E8, 5'h08);
    bus(1'b1, 10'h014, 32'h00000003);
    chk_enc(3'h4, 18'h00600, 5'h09);
    // Core latches the new level one edge after it is shown
    @(posedge clk);
    chk("core vector", 32'h00000600, {14'h0, ent});
  endtask : t_jump

  task automatic t_events;
    res <= '0;
    for (int i = 0; i < 6; i++)
    begin
      ev <= 6'h01 << i;
      repeat (2) @(posedge clk);
      bus(1'b0, 10'h0FC, 32'h0);
      chk("group23 event", 32'h1 << (8 + i), q);
    end
    ev <= 6'h00;
    res[494] <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, 10'h0FC, 32'h0);
    chk("group23 reserved", 32'h0, q);
    chk("idle level", 32'h0, {29'h0, lvl});
    // Lower levels meanwhile left the level 4 handler running
    chk("core busy", 32'h4, {29'h0, srv});
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(posedge clk);
    chk("core idle", 32'h0, {29'h0, srv});
  endtask : t_events

  task automatic t_wires;
    hvw <= 40'h8008000001;
    res[572] <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, 10'h11C, 32'h0);
    chk("group25 wires", 32'h08000001, q);
    bus(1'b0, 10'h12C, 32'h0);
    chk("group26 wires", 32'h00000800, q);
  endtask : t_wires

  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    fail_count = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    {adr, rd, wr, wd, res, ev, hvw, done} = '0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_aggr();
    t_jump();
    t_events();
    t_wires();
    summarize();
  end
endmodule : tb_top
